//--- hw/ftf_cfg.svh
// Constants for the float truncate-to-fixed datapath
`ifndef FTF_CFG_SVH
`define FTF_CFG_SVH
`define FTF_OP_COPROCESSOR_ONE_OPCODE      6'h11
`define FTF_FMT_SINGLE   5'h10
`define FTF_FMT_DOUBLE   5'h11
`define FTF_FN_LONG      6'h09
`define FTF_FN_WORD      6'h0d
`define FTF_OP_MSB       31
`define FTF_FMT_MSB      25
`define FTF_FT_MSB       20
`define FTF_FS_MSB       15
`define FTF_FD_MSB       10
`define FTF_FN_MSB       5
`define FTF_CSR_FLAG_V   2
`define FTF_CSR_EN_V     7
`define FTF_CSR_CAUSE_V  16
`define FTF_CSR_RST      32'h0000_0000
`define FTF_ADDR_CSR     32'h0000_0000
`define FTF_ADDR_MODE    32'h0000_0004
`define FTF_ADDR_RESULT  32'h0000_0008
`define FTF_ADDR_IRQST   32'h0000_000c
`define FTF_ADDR_IRQMSK  32'h0000_0010
`define FTF_MAX_W        64'h0000_0000_7fff_ffff
`define FTF_MAX_L        64'h7fff_ffff_ffff_ffff
`endif

//--- hw/ftf_pkg.sv
// Types for the float truncate-to-fixed datapath
package ftf_pkg;
  typedef enum logic [1:0] {
    FTF_IDLE = 2'b00,
    FTF_CONV = 2'b01,
    FTF_DONE = 2'b10
  } ftf_state_t;
  typedef enum logic [0:0] {
    FTF_PRECISE   = 1'b0,
    FTF_IMPRECISE = 1'b1
  } ftf_model_t;
endpackage

//--- hw/ftf_conv.sv
// Combinational float to signed integer truncation unit
`timescale 1ns/1ns
module ftf_conv
  import ftf_pkg::*;
(
  // Operand
  input  wire logic [63:0] src_i,
  input  wire logic        dbl_i,
  input  wire logic        long_i,
  // Result
  output logic      [63:0] value_o,
  output logic             invalid_o,
  output logic             inexact_o
);
  logic        sign;
  logic [11:0] exp_b;
  logic [52:0] mant;
  logic        special;
  logic signed [12:0] e;
  logic [116:0] wide;
  logic [63:0] mag;
  logic        lost;
  logic        big;

  always_comb begin
    if (dbl_i) begin
      sign    = src_i[63];
      exp_b   = {1'b0, src_i[62:52]};
      special = &src_i[62:52];
      mant    = {|src_i[62:52], src_i[51:0]};
      e       = $signed({1'b0, exp_b}) - 13'sd1075;
    end else begin
      sign    = src_i[31];
      exp_b   = {4'h0, src_i[30:23]};
      special = &src_i[30:23];
      mant    = {29'h0, |src_i[30:23], src_i[22:0]};
      e       = $signed({1'b0, exp_b}) - 13'sd150;
    end
    wide = '0;
    lost = 1'b0;
    big  = 1'b0;
    // Truncation toward zero: drop bits below the binary point
    if (e >= 13'sd64) begin
      big = |mant;
    end else if (e >= 0) begin
      wide = {64'h0, mant} << e[5:0];
      big  = |wide[116:64];
    end else if (e > -13'sd54) begin
      wide = {64'h0, mant} >> (-e);
      lost = |(mant & ~({53{1'b1}} << (-e)));
    end else begin
      lost = |mant;
    end
    mag = wide[63:0];
    // Range limits: -2^31..2^31-1 or -2^63..2^63-1
    if (long_i) begin
      big = big | (sign ? (mag > 64'h8000_0000_0000_0000)
                        : mag[63]);
    end else begin
      big = big | (|mag[63:32]) | (sign ? (mag[31:0] > 32'h8000_0000)
                                        : mag[31]);
    end
    invalid_o = special | big;
    inexact_o = lost & ~invalid_o;
    value_o   = sign ? (~mag + 64'h1) : mag;
    if (!long_i) begin
      value_o = {32'h0, value_o[31:0]};
    end
  end
endmodule

//--- hw/ftf_top.sv
// Float truncate-to-fixed datapath with AHB-Lite control registers
// Contract
// - Word variant truncates toward zero into 32-bit signed result.
// - Long variant truncates toward zero into 64-bit signed result.
// - Word: infinity, NaN or out of 32-bit range is invalid.
// - Long: infinity, NaN or out of 64-bit range is invalid.
// - Precise model: invalid sets the status flag bit.
// - Precise, enable set: no destination write, immediate exception.
// - Precise, enable clear: write maximum positive integer.
// - Imprecise: write maximum positive integer, flag untouched.
// - Imprecise with enable: exception signalled later, deferred.
// - Long result stored in 64-bit integer format.
// - Word variant can raise the listed exception kinds.
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "ftf_cfg.svh"
module ftf_top
  import ftf_pkg::*;
#(
  parameter int DEFER_CYCLES = 4
)(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Instruction issue
  input  wire logic        issue_valid_i,
  input  wire logic [31:0] issue_instr_i,
  input  wire logic [63:0] issue_src_i,
  input  wire logic        cop_usable_i,
  output logic             issue_ready_o,
  // Destination write
  output logic             dest_we_o,
  output logic [4:0]       dest_float_reg_o,
  output logic [63:0]      dest_data_o,
  // Exceptions
  output logic             exc_valid_o,
  output logic [2:0]       exc_code_o,
  output logic             exc_imprecise_o,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Interrupt
  output logic             irq_o
);
  localparam logic [2:0] EXC_CPU   = 3'd1;
  localparam logic [2:0] EXC_RSVD  = 3'd2;
  localparam logic [2:0] EXC_INV   = 3'd3;
  localparam logic [2:0] EXC_UNIMP = 3'd4;

  // The deferral counter is eight bits wide and must count at least once
  if (DEFER_CYCLES < 1 || DEFER_CYCLES > 255) begin : g_bad_defer
    $error("DEFER_CYCLES out of range");
  end

  ftf_state_t  state_reg;
  logic [31:0] fp_control_status_reg;
  ftf_model_t  model_reg;
  logic [63:0] result_reg;
  logic [2:0]  irq_st_reg;
  logic [2:0]  irq_msk_reg;
  logic [63:0] src_reg;
  logic        dbl_reg;
  logic        long_reg;
  logic [4:0]  fd_reg;
  logic        defer_pend_reg;
  logic [7:0]  defer_cnt_reg;
  logic [63:0] conv_value;
  logic        conv_invalid;
  logic        conv_inexact;

  // Decode
  logic [5:0] op_f;
  logic [4:0] fmt_f;
  logic [4:0] ft_f;
  logic [5:0] fn_f;
  logic       is_word;
  logic       is_long;
  logic       fmt_ok;
  logic       take;

  assign op_f  = issue_instr_i[`FTF_OP_MSB -: 6];
  assign fmt_f = issue_instr_i[`FTF_FMT_MSB -: 5];
  assign ft_f  = issue_instr_i[`FTF_FT_MSB -: 5];
  assign fn_f  = issue_instr_i[`FTF_FN_MSB -: 6];
  assign fmt_ok = (fmt_f == `FTF_FMT_SINGLE) ||
                  (fmt_f == `FTF_FMT_DOUBLE);
  assign is_word = (op_f == `FTF_OP_COPROCESSOR_ONE_OPCODE) && (fn_f == `FTF_FN_WORD)
                   && (ft_f == 5'h00);
  assign is_long = (op_f == `FTF_OP_COPROCESSOR_ONE_OPCODE) && (fn_f == `FTF_FN_LONG)
                   && (ft_f == 5'h00);
  assign issue_ready_o = (state_reg == FTF_IDLE);
  assign take = issue_valid_i && issue_ready_o;

  ftf_conv u_conv (
    .src_i     (src_reg),
    .dbl_i     (dbl_reg),
    .long_i    (long_reg),
    .value_o   (conv_value),
    .invalid_o (conv_invalid),
    .inexact_o (conv_inexact)
  );

  logic inv_now;
  logic en_v;
  logic fin;
  assign fin     = (state_reg == FTF_CONV);
  assign inv_now = fin && conv_invalid;
  assign en_v    = fp_control_status_reg[`FTF_CSR_EN_V];

  // Operand capture and sequencing
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= FTF_IDLE;
      src_reg   <= 64'h0;
      dbl_reg   <= 1'b0;
      long_reg  <= 1'b0;
      fd_reg    <= 5'h0;
    end else begin
      unique case (state_reg)
        FTF_IDLE: begin
          if (take && cop_usable_i && fmt_ok && (is_word || is_long)) begin
            state_reg <= FTF_CONV;
            src_reg   <= issue_src_i;
            dbl_reg   <= fmt_f[0];
            long_reg  <= is_long;
            fd_reg    <= issue_instr_i[`FTF_FD_MSB -: 5];
          end
        end
        FTF_CONV: state_reg <= FTF_DONE;
        FTF_DONE: state_reg <= FTF_IDLE;
        default:  state_reg <= FTF_IDLE;
      endcase
    end
  end

  // Destination write
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dest_we_o        <= 1'b0;
      dest_float_reg_o <= 5'h0;
      dest_data_o      <= 64'h0;
    end else begin
      dest_we_o <= 1'b0;
      if (fin) begin
        dest_float_reg_o <= fd_reg;
        if (!conv_invalid) begin
          dest_we_o   <= 1'b1;
          dest_data_o <= conv_value;
        end else if (model_reg == FTF_IMPRECISE || !en_v) begin
          dest_we_o   <= 1'b1;
          dest_data_o <= long_reg ? `FTF_MAX_L : `FTF_MAX_W;
        end
      end
    end
  end

  // Exception reporting
  logic defer_fire;
  logic exc_sync;
  assign defer_fire = defer_pend_reg && (defer_cnt_reg == 8'h0);
  // A synchronous exception in the same cycle holds the deferred one back
  assign exc_sync = (take && !(cop_usable_i && fmt_ok &&
                               (is_word || is_long))) ||
                    (inv_now && model_reg == FTF_PRECISE && en_v);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      exc_valid_o     <= 1'b0;
      exc_code_o      <= 3'd0;
      exc_imprecise_o <= 1'b0;
    end else begin
      exc_valid_o     <= 1'b0;
      exc_imprecise_o <= 1'b0;
      if (take && !cop_usable_i) begin
        exc_valid_o <= 1'b1;
        exc_code_o  <= EXC_CPU;
      end else if (take && !(is_word || is_long)) begin
        exc_valid_o <= 1'b1;
        exc_code_o  <= EXC_RSVD;
      end else if (take && !fmt_ok) begin
        exc_valid_o <= 1'b1;
        exc_code_o  <= EXC_UNIMP;
      end else if (inv_now && model_reg == FTF_PRECISE && en_v) begin
        exc_valid_o <= 1'b1;
        exc_code_o  <= EXC_INV;
      end else if (defer_fire) begin
        exc_valid_o     <= 1'b1;
        exc_imprecise_o <= 1'b1;
        exc_code_o      <= EXC_INV;
      end
    end
  end

  // Deferred imprecise invalid exception
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      defer_pend_reg <= 1'b0;
      defer_cnt_reg  <= 8'h0;
    end else if (inv_now && model_reg == FTF_IMPRECISE && en_v) begin
      defer_pend_reg <= 1'b1;
      defer_cnt_reg  <= 8'(DEFER_CYCLES);
    end else if (defer_pend_reg) begin
      if (defer_cnt_reg == 8'h0) begin
        if (!exc_sync) begin
          defer_pend_reg <= 1'b0;
        end
      end else begin
        defer_cnt_reg <= defer_cnt_reg - 8'h1;
      end
    end
  end

  // AHB-Lite address phase capture
  logic        wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic        acc;
  assign acc = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0;
    end else begin
      wr_pend_reg <= acc && hwrite_i;
      if (acc) begin
        wr_addr_reg <= {haddr_i[31:2], 2'b00};
      end
    end
  end

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  // Status events: 0 invalid, 1 inexact, 2 exception raised
  logic [2:0] ev;
  assign ev = {exc_valid_o, fin && conv_inexact, inv_now};

  // Control, status and interrupt registers; hardware set wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fp_control_status_reg <= `FTF_CSR_RST;
      model_reg             <= FTF_PRECISE;
      irq_st_reg            <= 3'h0;
      irq_msk_reg           <= 3'h0;
    end else begin
      if (wr_pend_reg && hit(wr_addr_reg, `FTF_ADDR_CSR)) begin
        fp_control_status_reg <= hwdata_i;
      end
      if (wr_pend_reg && hit(wr_addr_reg, `FTF_ADDR_MODE)) begin
        model_reg <= ftf_model_t'(hwdata_i[0]);
      end
      if (wr_pend_reg && hit(wr_addr_reg, `FTF_ADDR_IRQMSK)) begin
        irq_msk_reg <= hwdata_i[2:0];
      end
      if (inv_now) begin
        fp_control_status_reg[`FTF_CSR_CAUSE_V] <= 1'b1;
        if (model_reg == FTF_PRECISE) begin
          fp_control_status_reg[`FTF_CSR_FLAG_V] <= 1'b1;
        end
      end
      irq_st_reg <= (irq_st_reg &
                     ~((wr_pend_reg && hit(wr_addr_reg, `FTF_ADDR_IRQST))
                       ? hwdata_i[2:0] : 3'h0)) | ev;
    end
  end

  // Last result, low 32 bits readable by software
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_reg <= 64'h0;
    end else if (dest_we_o) begin
      result_reg <= dest_data_o;
    end
  end

  // Read data, registered at the end of the address phase for the data phase
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hrdata_o <= 32'h0;
    end else if (acc && !hwrite_i) begin
      unique case ({haddr_i[31:2], 2'b00})
        `FTF_ADDR_CSR:    hrdata_o <= fp_control_status_reg;
        `FTF_ADDR_MODE:   hrdata_o <= {31'h0, model_reg};
        `FTF_ADDR_RESULT: hrdata_o <= result_reg[31:0];
        `FTF_ADDR_IRQST:  hrdata_o <= {29'h0, irq_st_reg};
        `FTF_ADDR_IRQMSK: hrdata_o <= {29'h0, irq_msk_reg};
        default:          hrdata_o <= 32'h0;
      endcase
    end
  end

  assign irq_o = |(irq_st_reg & irq_msk_reg);
endmodule

//--- bench/ftf_top_properties.sv
// Concurrent checks on the truncate-to-fixed datapath ports
`timescale 1ns/1ns
`include "ftf_cfg.svh"
module ftf_top_properties
  import ftf_pkg::*;
#(
  parameter int DEFER_CYCLES = 4
)(
  // Clock, reset and issue side
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        issue_valid_i,
  input  wire logic [31:0] issue_instr_i,
  input  wire logic        cop_usable_i,
  input  wire logic        issue_ready_o,
  // Results and exceptions
  input  wire logic        dest_we_o,
  input  wire logic [4:0]  dest_float_reg_o,
  input  wire logic [63:0] dest_data_o,
  input  wire logic        exc_valid_o,
  input  wire logic [2:0]  exc_code_o,
  input  wire logic        exc_imprecise_o
);
  logic       take;
  logic       fn_ok;
  logic       op_ok;
  logic       fmt_bad;
  logic       word_reg;
  logic [4:0] fd_reg;
  assign take  = issue_valid_i && issue_ready_o;
  assign fn_ok = issue_instr_i[5:0] == `FTF_FN_WORD ||
                 issue_instr_i[5:0] == `FTF_FN_LONG;
  assign op_ok = issue_instr_i[31:26] == `FTF_OP_COPROCESSOR_ONE_OPCODE && cop_usable_i &&
                 issue_instr_i[20:16] == 5'h00 &&
                 (issue_instr_i[25:21] == `FTF_FMT_SINGLE ||
                  issue_instr_i[25:21] == `FTF_FMT_DOUBLE);
  assign fmt_bad = issue_instr_i[31:26] == `FTF_OP_COPROCESSOR_ONE_OPCODE && cop_usable_i &&
                   issue_instr_i[20:16] == 5'h00 &&
                   issue_instr_i[25:21] != `FTF_FMT_SINGLE &&
                   issue_instr_i[25:21] != `FTF_FMT_DOUBLE;
  // Capture what the pending result must carry
  always_ff @(posedge clk_i) begin
    if (take) begin
      word_reg <= issue_instr_i[5:0] == `FTF_FN_WORD;
      fd_reg   <= issue_instr_i[10:6];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_busy;
    !issue_ready_o [*2] ##1 issue_ready_o;
  endsequence
  sequence s_answer;
    ##2 (dest_we_o || exc_valid_o);
  endsequence
  property p_busy;
    take && op_ok && fn_ok |=> s_busy;
  endproperty
  property p_answer;
    take && op_ok && fn_ok |-> s_answer;
  endproperty
  property p_fd;
    dest_we_o |-> dest_float_reg_o == fd_reg;
  endproperty
  property p_zext;
    dest_we_o && word_reg |-> dest_data_o[63:32] == 32'h0000_0000;
  endproperty
  property p_hold;
    !dest_we_o |-> $stable(dest_data_o);
  endproperty
  property p_one_kind;
    dest_we_o |-> !exc_valid_o || exc_imprecise_o;
  endproperty
  property p_unimp;
    take && fmt_bad && fn_ok |=> exc_valid_o && exc_code_o == 3'h4;
  endproperty
  property p_unusable;
    take && !cop_usable_i |=> exc_valid_o && exc_code_o == 3'h1;
  endproperty
  property p_reserved;
    take && op_ok && !fn_ok |=> exc_valid_o && exc_code_o == 3'h2;
  endproperty
  property p_imp;
    exc_imprecise_o |-> exc_valid_o && exc_code_o == 3'h3;
  endproperty
  a_busy: assert property (p_busy)
    else $error("issue ready not low for two cycles");
  a_answer: assert property (p_answer)
    else $error("no answer two cycles after issue");
  a_fd: assert property (p_fd)
    else $error("destination index wrong");
  a_zext: assert property (p_zext)
    else $error("word result not zero extended");
  a_hold: assert property (p_hold)
    else $error("destination data changed without write");
  a_one_kind: assert property (p_one_kind)
    else $error("write and exception together");
  a_unusable: assert property (p_unusable)
    else $error("unusable coprocessor not reported");
  a_reserved: assert property (p_reserved)
    else $error("bad function code not reported");
  a_imp: assert property (p_imp)
    else $error("deferred exception malformed");
  a_unimp: assert property (p_unimp)
    else $error("unsupported format not reported");
endmodule
bind ftf_top ftf_top_properties #(.DEFER_CYCLES(DEFER_CYCLES)) u_props (
  .clk_i, .srst_i, .issue_valid_i, .issue_instr_i, .cop_usable_i,
  .issue_ready_o, .dest_we_o, .dest_float_reg_o, .dest_data_o,
  .exc_valid_o, .exc_code_o, .exc_imprecise_o
);

//--- bench/ftf_issuer.sv
// Issue-side model that offers one instruction until it is taken
`timescale 1ns/1ns
module ftf_issuer (
  // Clock and bench request
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [63:0] src_i,
  // Towards the datapath
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic [31:0]      instr_o,
  output logic [63:0]      src_o
);
  initial begin
    valid_o = 1'b0;
    instr_o = 32'h0000_0000;
    src_o   = 64'h0;
  end
  // Registers and operand are valid for the format
  always @(posedge clk_i) begin
    if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      instr_o <= ~instr_o;
      src_o   <= ~src_o;
    end else if (!valid_o && req_i) begin
      valid_o <= 1'b1;
      instr_o <= instr_i;
      src_o   <= src_i;
    end
  end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the truncate-to-fixed datapath
`timescale 1ns/1ns
`include "ftf_cfg.svh"
module testbench;
  import ftf_pkg::*;
  logic clk_i = 0, srst_i = 1, cop_usable_i = 1, req = 0;
  logic hsel_i = 0, hwrite_i = 0, issue_valid_i, issue_ready_o, irq_o;
  logic dest_we_o, exc_valid_o, exc_imprecise_o, hreadyout_o, hresp_o;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h2, exc_code_o;
  logic [4:0]  dest_float_reg_o;
  logic [31:0] haddr_i = 0, hwdata_i = 0, rq_ins = 0, issue_instr_i, hrdata_o;
  logic [63:0] rq_src = 0, issue_src_i, dest_data_o;
  logic        we, ex;
  logic [2:0]  cd;
  logic [31:0] rd;
  int miscompares = 0, tests_run = 0;
  localparam logic [4:0] SG = `FTF_FMT_SINGLE, DB = `FTF_FMT_DOUBLE;
  localparam logic [5:0] WD = `FTF_FN_WORD, LG = `FTF_FN_LONG;
  always #5 clk_i = ~clk_i;
  ftf_issuer u_iss (.clk_i, .req_i(req), .instr_i(rq_ins), .src_i(rq_src),
    .ready_i(issue_ready_o), .valid_o(issue_valid_i),
    .instr_o(issue_instr_i), .src_o(issue_src_i));
  ftf_top #(.DEFER_CYCLES(4)) u_dut (.clk_i, .srst_i, .issue_valid_i,
    .issue_instr_i, .issue_src_i, .cop_usable_i, .issue_ready_o,
    .dest_we_o, .dest_float_reg_o, .dest_data_o, .exc_valid_o, .exc_code_o,
    .exc_imprecise_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .irq_o);
  function automatic logic [31:0] op(logic [4:0] f, logic [5:0] fn);
    op = {`FTF_OP_COPROCESSOR_ONE_OPCODE, f, 5'h00, 5'h03, 5'h05, fn};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= a;
    hwrite_i <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 20);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 40);
    if (hreadyout_o !== 1'b1) begin
      miscompares++;
    end
    rd = hrdata_o;
    hsel_i <= 1'b0;
    // Let the write of the data phase settle before the caller looks
    #1;
  endtask
  task automatic run(input logic [31:0] ins, input logic [63:0] src);
    int n;
    n = 0;
    @(posedge clk_i);
    req    <= 1'b1;
    rq_ins <= ins;
    rq_src <= src;
    @(posedge clk_i);
    req <= 1'b0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (dest_we_o !== 1'b1 && exc_valid_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
    end
    we = dest_we_o;
    ex = exc_valid_o;
    cd = exc_code_o;
  endtask
  task automatic t_convert();
    run(op(SG, WD), 64'h4030_0000);
    chk(dest_data_o, 64'h2);
    chk(dest_float_reg_o, 5'h05);
    run(op(DB, WD), 64'hc00c_0000_0000_0000);
    chk(dest_data_o, 64'hffff_fffd);
    run(op(SG, WD), 64'hcf00_0000);
    chk(dest_data_o, 64'h8000_0000);
    run(op(DB, LG), 64'hc00c_0000_0000_0000);
    chk(dest_data_o, 64'hffff_ffff_ffff_fffd);
    run(op(SG, LG), 64'h4030_0000);
    chk(dest_data_o, 64'h2);
  endtask
  task automatic t_invalid();
    bus(1'b1, `FTF_ADDR_IRQMSK, 32'h1);
    run(op(SG, WD), 64'hcf00_0001);
    chk(dest_data_o, `FTF_MAX_W);
    run(op(DB, LG), 64'h43e0_0000_0000_0000);
    chk(dest_data_o, `FTF_MAX_L);
    run(op(SG, WD), 64'h4f00_0000);
    chk(dest_data_o, `FTF_MAX_W);
    bus(1'b0, `FTF_ADDR_RESULT, 32'h0);
    chk(rd, 32'h7fff_ffff);
    bus(1'b0, `FTF_ADDR_CSR, 32'h0);
    chk(rd[2], 1'b1);
    chk(irq_o, 1'b1);
    chk({hreadyout_o, hresp_o}, 2'b10);
    bus(1'b1, `FTF_ADDR_IRQST, 32'h1);
    chk(irq_o, 1'b0);
    run(op(DB, LG), 64'hc3e0_0000_0000_0000);
    chk(dest_data_o, 64'h8000_0000_0000_0000);
    run(op(DB, LG), 64'h7ff0_0000_0000_0000);
    chk(dest_data_o, `FTF_MAX_L);
    bus(1'b0, 32'h0000_0020, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_trap();
    bus(1'b1, `FTF_ADDR_CSR, 32'h80);
    run(op(SG, LG), 64'h7f80_0000);
    chk({we, ex, cd}, {2'b01, 3'h3});
    bus(1'b0, `FTF_ADDR_CSR, 32'h0);
    chk(rd[2], 1'b1);
  endtask
  task automatic t_deferred();
    int n;
    bus(1'b1, `FTF_ADDR_MODE, 32'h1);
    bus(1'b1, `FTF_ADDR_CSR, 32'h80);
    run(op(DB, WD), 64'h7ff8_0000_0000_0000);
    chk({we, ex}, 2'b10);
    chk(dest_data_o, `FTF_MAX_W);
    n = 0;
    while (exc_imprecise_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({exc_valid_o, exc_imprecise_o, exc_code_o, n > 0},
        {2'b11, 3'h3, 1'b1});
    bus(1'b0, `FTF_ADDR_CSR, 32'h0);
    chk(rd[2], 1'b0);
    bus(1'b1, `FTF_ADDR_MODE, 32'h0);
  endtask
  task automatic t_decode();
    cop_usable_i <= 1'b0;
    run(op(SG, WD), 64'h0);
    chk({ex, cd}, {1'b1, 3'h1});
    cop_usable_i <= 1'b1;
    run(op(SG, 6'h0c), 64'h0);
    chk({ex, cd}, {1'b1, 3'h2});
    run(op(5'h14, WD), 64'h0);
    chk({ex, cd}, {1'b1, 3'h4});
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 0;
    t_convert();
    t_invalid();
    t_trap();
    t_deferred();
    t_decode();
    stop_test();
  end
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end
endmodule
